//--- verilog/fmw_pkg.sv
package fmw_pkg;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int FLT_PULSE_NS  = 50000;
  localparam int FLT_PULSE_CYC = (FLT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIAG_STEP_NS  = 1000;
  localparam int DIAG_STEP_CYC = (DIAG_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WD_STEP_NS    = 1000000;
  localparam int WD_STEP_CYC   = (WD_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NUM_CH        = 12;

  // --------------------------------------------------------------------------
  // Register map
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_FLAGS = 8'h04;
  localparam logic [7:0] ADDR_STAT  = 8'h08;

  localparam int CTRL_POR_CLR = 0;
  localparam int CTRL_ERR_CLR = 1;
  localparam int CTRL_WD_LSB  = 4;
  localparam int CTRL_DPW_LSB = 8;
  localparam int CTRL_LST_LSB = 12;
  localparam int FLG_OPEN_LSB = 8;
  localparam int STAT_FS_BIT  = 2;
  localparam int STAT_CND_LSB = 4;

  localparam logic [3:0] WD_PERIOD_RST = 4'h8;
  localparam logic [3:0] WD_OFF        = 4'h0;
  localparam logic [3:0] WD_NV_DIRECT  = 4'hf;
  localparam logic [3:0] DPW_RST       = 4'h3;
  localparam logic [7:0] LST_RST       = 8'h40;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {ST_POR, ST_INIT, ST_NORMAL, ST_FAILSAFE} fmw_state_t;

  typedef struct packed {
    logic undervoltage_lockout;
    logic tsd2;
    logic tsd1;
    logic twarn;
    logic uv;
    logic bias;
    logic low_supply;
  } fmw_cond_t;

  typedef struct packed {
    logic any_out;
    logic overtemp;
    logic twarn;
    logic bias;
    logic uv;
    logic low_supply;
    logic err;
    logic por;
  } fmw_flags_t;

  typedef struct packed {
    logic valid;
    logic crc_ok;
    logic addr_match;
    logic broadcast;
  } fmw_frame_t;

endpackage : fmw_pkg

//--- verilog/fmw_pulse_timer.sv
`timescale 1ns/1ps
module fmw_pulse_timer #(
  parameter int CYC = 6250
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic reset_i,
  // Trigger and pulse
  input  wire logic start_i,
  output logic      busy_o
);
  localparam int W = $clog2(CYC + 1);

  if (CYC < 1) begin : g_bad_cyc
    $error("CYC must be at least 1");
  end

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;

  // --------------------------------------------------------------------------
  // Counter
  // --------------------------------------------------------------------------
  // Retrigger restarts the full width so every event gets its whole pulse
  always_comb begin
    nxt_cnt = cnt_ff;
    if (start_i) begin
      nxt_cnt = W'(CYC);
    end else if (cnt_ff != '0) begin
      nxt_cnt = cnt_ff - W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign busy_o = (cnt_ff != '0);

endmodule : fmw_pulse_timer

//--- verilog/fmw_open_det.sv
`timescale 1ns/1ps
module fmw_open_det #(
  parameter int N    = 12,
  parameter int STEP = 125
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Channel sense
  input  wire logic [N-1:0] on_i,
  input  wire logic [N-1:0] low_i,
  input  wire logic         inhibit_i,
  input  wire logic [3:0]   dpw_i,
  // Results
  output logic      [N-1:0] evt_o,
  output logic      [N-1:0] ok_o
);
  localparam int W = $clog2(16 * STEP + 2);

  if (N < 1 || STEP < 1) begin : g_bad_param
    $error("N and STEP must be at least 1");
  end

  logic [W-1:0] limit;
  assign limit = W'(({1'b0, dpw_i} + 5'h1) * STEP);

  // --------------------------------------------------------------------------
  // Per-channel deglitch
  // --------------------------------------------------------------------------
  for (genvar i = 0; i < N; i++) begin : g_ch
    logic [W-1:0] bad_ff, good_ff, nxt_bad, nxt_good;
    logic         rep_ff, nxt_rep, ok_ff, nxt_ok;

    always_comb begin
      nxt_bad  = '0;
      nxt_good = '0;
      nxt_rep  = rep_ff;
      nxt_ok   = ok_ff;
      evt_o[i] = 1'b0;
      if (on_i[i] && !inhibit_i) begin
        if (low_i[i]) begin
          nxt_ok  = 1'b0;
          nxt_bad = (bad_ff > limit) ? bad_ff : bad_ff + W'(1);
          if (bad_ff == limit && !rep_ff) begin
            evt_o[i] = 1'b1;
            nxt_rep  = 1'b1;
          end
        end else begin
          nxt_good = (good_ff > limit) ? good_ff : good_ff + W'(1);
          if (good_ff == limit) begin
            nxt_ok  = 1'b1;
            nxt_rep = 1'b0;
          end
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        bad_ff  <= '0;
        good_ff <= '0;
        rep_ff  <= 1'b0;
        ok_ff   <= 1'b0;
      end else begin
        bad_ff  <= nxt_bad;
        good_ff <= nxt_good;
        rep_ff  <= nxt_rep;
        ok_ff   <= nxt_ok;
      end
    end

    assign ok_o[i] = ok_ff;
  end

endmodule : fmw_open_det

//--- verilog/fmw_top.sv
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
// Function
// - Lockout enters power-on state; recovery gives init with power-on and error flags
// - Writing 1 to clear bits clears power-on or error flag; bits self-clear
// - Low supply gives one 50 us fault pulse, sets low-supply and error flags
// - Low supply suppresses open detection and single-LED short diagnosis
// - Undervoltage sinks fault pin constantly, sets flags, disables all outputs
// - Outputs return above rising threshold; host clears flags with error clear
// - Bias resistor fault sinks fault pin constantly and sets bias and error flags
// - Bias recovery releases pin; host error clear then clears flags
// - Thermal warning gives 50 us pulse, sets flags; host clears after cooling
// - Overtemperature disables outputs, sinks pin, sets flags; resumes on cooling
// - Second overtemperature shuts down, sinks pin, sets power-on and error flags
// - Valid addressed non-broadcast frame with good checksum restarts watchdog
// - Watchdog overflow enters fail-safe state chosen by select pin
// - Four-bit period; zero disables; nonvolatile 0xf enters fail-safe directly
// - Open faults judged only in on-pulses longer than diagnostic width
// - No open detection or report while supply is low
// - Headroom low beyond width gives pulse, sets channel, any-output, error flags
// - Diagnostic pulse width comes from a four-bit field
module fmw_top
  import fmw_pkg::*;
#(
  parameter int PULSE_CYC = fmw_pkg::FLT_PULSE_CYC,
  parameter int WD_CYC    = fmw_pkg::WD_STEP_CYC,
  parameter int N         = fmw_pkg::NUM_CH
) (
  // Clock and reset
  input  wire logic               clk_i,
  input  wire logic               reset_i,
  // AHB-Lite slave
  input  wire logic               hsel_i,
  input  wire logic [31:0]        haddr_i,
  input  wire logic [1:0]         htrans_i,
  input  wire logic               hwrite_i,
  input  wire logic [2:0]         hsize_i,
  input  wire logic [31:0]        hwdata_i,
  input  wire logic               hready_i,
  output logic      [31:0]        hrdata_o,
  output logic                    hreadyout_o,
  output logic                    hresp_o,
  // Analog condition inputs
  input  wire fmw_pkg::fmw_cond_t cond_i,
  input  wire logic [N-1:0]       ch_on_i,
  input  wire logic [N-1:0]       ch_headroom_low_i,
  // Serial link frame status
  input  wire fmw_pkg::fmw_frame_t frame_i,
  input  wire logic               failsafe_select_pin_i,
  input  wire logic [3:0]         watchdog_period_nonvolatile_i,
  // Fault pin and device control
  output logic                    fault_pin_o,
  output logic                    fault_pin_oe_o,
  output logic                    outputs_enable_o,
  output logic                    suppress_diag_o,
  output logic [7:0]              low_supply_threshold_o,
  output logic                    failsafe_o,
  output logic                    failsafe_state_o
);
  import fmw_pkg::*;

  localparam int PW = $clog2(WD_CYC + 1);

  // Open flags share the flag word, so at most 24 channels fit
  if (N < 1 || N > 24 || PULSE_CYC < 1 || WD_CYC < 1) begin : g_bad_param
    $error("Bad parameters");
  end

  // --------------------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------------------
  logic        act_ff, wr_ff, nxt_act, nxt_wr;
  logic [7:0]  addr_ff, nxt_addr;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        power_on_clear_bit_ff, error_clear_bit_ff, nxt_power_on_clear_bit, nxt_error_clear_bit;
  logic [3:0]  wd_period_ff, nxt_wd_period;
  logic [3:0]  dpw_ff, nxt_dpw;
  logic [7:0]  lst_ff, nxt_lst;

  fmw_flags_t  flags_ff, nxt_flags;
  logic [N-1:0] open_ff, nxt_open;
  fmw_state_t  state_ff, nxt_state;
  logic        fs_sel_ff, nxt_fs_sel;
  logic        hold;

  // Lockout and shutdown act as an internal reset of the configuration
  assign hold = cond_i.undervoltage_lockout | cond_i.tsd2;

  always_comb begin
    nxt_act       = 1'b0;
    nxt_wr        = 1'b0;
    nxt_addr      = addr_ff;
    nxt_rdata     = rdata_ff;
    nxt_power_on_clear_bit   = 1'b0;
    nxt_error_clear_bit   = 1'b0;
    nxt_wd_period = wd_period_ff;
    nxt_dpw       = dpw_ff;
    nxt_lst       = lst_ff;
    if (hsel_i && hready_i && htrans_i[1]) begin
      nxt_act   = 1'b1;
      nxt_wr    = hwrite_i;
      nxt_addr  = haddr_i[7:0];
      nxt_rdata = '0;
      if (!hwrite_i) begin
        case (haddr_i[7:0])
          ADDR_CTRL: begin
            nxt_rdata[CTRL_WD_LSB +: 4]  = wd_period_ff;
            nxt_rdata[CTRL_DPW_LSB +: 4] = dpw_ff;
            nxt_rdata[CTRL_LST_LSB +: 8] = lst_ff;
          end
          ADDR_FLAGS: begin
            nxt_rdata[7:0]              = flags_ff;
            nxt_rdata[FLG_OPEN_LSB +: N] = open_ff;
          end
          ADDR_STAT: begin
            nxt_rdata[1:0]                = state_ff;
            nxt_rdata[STAT_FS_BIT]        = fs_sel_ff;
            nxt_rdata[STAT_CND_LSB +: 7]  = cond_i;
          end
          default: nxt_rdata = '0;
        endcase
      end
    end
    if (act_ff && wr_ff && addr_ff == ADDR_CTRL) begin
      nxt_power_on_clear_bit   = hwdata_i[CTRL_POR_CLR];
      nxt_error_clear_bit   = hwdata_i[CTRL_ERR_CLR];
      nxt_wd_period = hwdata_i[CTRL_WD_LSB +: 4];
      nxt_dpw       = hwdata_i[CTRL_DPW_LSB +: 4];
      nxt_lst       = hwdata_i[CTRL_LST_LSB +: 8];
    end
    if (hold) begin
      nxt_wd_period = WD_PERIOD_RST;
      nxt_dpw       = DPW_RST;
      nxt_lst       = LST_RST;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      act_ff       <= 1'b0;
      wr_ff        <= 1'b0;
      addr_ff      <= '0;
      rdata_ff     <= '0;
      power_on_clear_bit_ff   <= 1'b0;
      error_clear_bit_ff   <= 1'b0;
      wd_period_ff <= WD_PERIOD_RST;
      dpw_ff       <= DPW_RST;
      lst_ff       <= LST_RST;
    end else begin
      act_ff       <= nxt_act;
      wr_ff        <= nxt_wr;
      addr_ff      <= nxt_addr;
      rdata_ff     <= nxt_rdata;
      power_on_clear_bit_ff   <= nxt_power_on_clear_bit;
      error_clear_bit_ff   <= nxt_error_clear_bit;
      wd_period_ff <= nxt_wd_period;
      dpw_ff       <= nxt_dpw;
      lst_ff       <= nxt_lst;
    end
  end

  // --------------------------------------------------------------------------
  // Open detection and pulse timer
  // --------------------------------------------------------------------------
  logic [N-1:0] open_evt, open_ok;
  logic         pulse_start, pulse_busy;
  logic         ls_q_ff, tw_q_ff;

  fmw_open_det #(
    .N    (N),
    .STEP (DIAG_STEP_CYC)
  ) u_open (
    .clk_i     (clk_i),
    .reset_i   (reset_i | hold),
    .on_i      (ch_on_i),
    .low_i     (ch_headroom_low_i),
    .inhibit_i (cond_i.low_supply),
    .dpw_i     (dpw_ff),
    .evt_o     (open_evt),
    .ok_o      (open_ok)
  );

  assign pulse_start = (cond_i.low_supply & ~ls_q_ff) | (cond_i.twarn & ~tw_q_ff)
                     | (|open_evt);

  fmw_pulse_timer #(
    .CYC (PULSE_CYC)
  ) u_pulse (
    .clk_i   (clk_i),
    .reset_i (reset_i | hold),
    .start_i (pulse_start),
    .busy_o  (pulse_busy)
  );

  // --------------------------------------------------------------------------
  // Flags
  // --------------------------------------------------------------------------
  fmw_flags_t set_f, clr_f;
  logic [N-1:0] open_clr;

  always_comb begin
    set_f            = '0;
    set_f.por        = hold | state_ff == ST_POR;
    set_f.low_supply = cond_i.low_supply;
    set_f.uv         = cond_i.uv;
    set_f.bias       = cond_i.bias;
    set_f.twarn      = cond_i.twarn;
    set_f.overtemp   = cond_i.tsd1;
    set_f.any_out    = |open_evt;
    set_f.err        = |set_f;

    clr_f            = '0;
    clr_f.por        = power_on_clear_bit_ff & ~hold;
    clr_f.low_supply = error_clear_bit_ff & ~cond_i.low_supply;
    clr_f.uv         = error_clear_bit_ff & ~cond_i.uv;
    clr_f.bias       = error_clear_bit_ff & ~cond_i.bias;
    clr_f.twarn      = error_clear_bit_ff & ~cond_i.twarn;
    clr_f.overtemp   = error_clear_bit_ff & ~cond_i.tsd1;
    open_clr         = {N{error_clear_bit_ff}} & (open_ok | {N{cond_i.low_supply}});
    clr_f.any_out    = error_clear_bit_ff & ~|(open_ff & ~open_clr);
    clr_f.err        = (error_clear_bit_ff | power_on_clear_bit_ff)
                     & ~|(flags_ff[7:2] & ~clr_f[7:2])
                     & ~(flags_ff.por & ~clr_f.por & ~error_clear_bit_ff);

    // Set wins over a clear in the same cycle
    nxt_flags = set_f | (flags_ff & ~clr_f);
    nxt_open  = open_evt | (open_ff & ~open_clr);
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      flags_ff <= '0;
      open_ff  <= '0;
      ls_q_ff  <= 1'b0;
      tw_q_ff  <= 1'b0;
    end else begin
      flags_ff <= nxt_flags;
      open_ff  <= nxt_open;
      ls_q_ff  <= cond_i.low_supply;
      tw_q_ff  <= cond_i.twarn;
    end
  end

  // --------------------------------------------------------------------------
  // Device state and watchdog
  // --------------------------------------------------------------------------
  logic [PW-1:0] pre_ff, nxt_pre;
  logic [3:0]    unit_ff, nxt_unit;
  logic          kick, wd_ovf;

  assign kick = frame_i.valid & frame_i.crc_ok & frame_i.addr_match & ~frame_i.broadcast;

  always_comb begin
    nxt_pre    = pre_ff;
    nxt_unit   = unit_ff;
    nxt_state  = state_ff;
    nxt_fs_sel = fs_sel_ff;
    wd_ovf     = 1'b0;
    if (state_ff != ST_NORMAL || kick || wd_period_ff == WD_OFF) begin
      nxt_pre  = '0;
      nxt_unit = '0;
    end else if (pre_ff == PW'(WD_CYC - 1)) begin
      nxt_pre  = '0;
      nxt_unit = unit_ff + 4'h1;
      wd_ovf   = (unit_ff + 4'h1 == wd_period_ff);
    end else begin
      nxt_pre  = pre_ff + PW'(1);
    end
    case (state_ff)
      ST_POR:    nxt_state = ST_INIT;
      ST_INIT:   nxt_state = ST_NORMAL;
      ST_NORMAL: begin
        if (wd_ovf || watchdog_period_nonvolatile_i == WD_NV_DIRECT) begin
          nxt_state  = ST_FAILSAFE;
          nxt_fs_sel = failsafe_select_pin_i;
        end
      end
      ST_FAILSAFE: begin
        if (kick && watchdog_period_nonvolatile_i != WD_NV_DIRECT) begin
          nxt_state = ST_NORMAL;
        end
      end
      default: nxt_state = ST_POR;
    endcase
    if (hold) begin
      nxt_state = ST_POR;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_ff  <= ST_POR;
      fs_sel_ff <= 1'b0;
      pre_ff    <= '0;
      unit_ff   <= '0;
    end else begin
      state_ff  <= nxt_state;
      fs_sel_ff <= nxt_fs_sel;
      pre_ff    <= nxt_pre;
      unit_ff   <= nxt_unit;
    end
  end

  // --------------------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------------------
  logic oe_ff, en_ff, sup_ff, fs_ff;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      oe_ff  <= 1'b0;
      en_ff  <= 1'b0;
      sup_ff <= 1'b0;
      fs_ff  <= 1'b0;
    end else begin
      oe_ff  <= pulse_busy | cond_i.uv | cond_i.bias | cond_i.tsd1 | cond_i.tsd2;
      en_ff  <= (nxt_state == ST_NORMAL || nxt_state == ST_FAILSAFE)
                & ~cond_i.uv & ~cond_i.tsd1 & ~hold;
      sup_ff <= cond_i.low_supply;
      fs_ff  <= (nxt_state == ST_FAILSAFE);
    end
  end

  // Open-drain: the pin is only ever pulled low
  assign fault_pin_o            = 1'b0;
  assign fault_pin_oe_o         = oe_ff;
  assign outputs_enable_o       = en_ff;
  assign suppress_diag_o        = sup_ff;
  assign failsafe_o             = fs_ff;
  assign failsafe_state_o       = fs_sel_ff;
  assign low_supply_threshold_o = lst_ff;
  assign hrdata_o               = rdata_ff;
  assign hreadyout_o            = 1'b1;
  assign hresp_o                = 1'b0;

endmodule : fmw_top

//--- tb/fmw_assertions.sv
`timescale 1ns/1ps
module fmw_checker #(
  parameter int PULSE_CYC = 20
) (
  // Watched ports
  input wire logic                clk_i,
  input wire logic                reset_i,
  input wire fmw_pkg::fmw_cond_t  cond_i,
  input wire fmw_pkg::fmw_frame_t frame_i,
  input wire logic                failsafe_select_pin_i,
  input wire logic [3:0]          watchdog_period_nonvolatile_i,
  input wire logic                fault_pin_oe_o,
  input wire logic                outputs_enable_o,
  input wire logic                failsafe_o,
  input wire logic                failsafe_state_o
);
  import fmw_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // --------
  // Pulse length
  // --------
  logic        sink;
  logic        kick;
  logic [15:0] hi_ff;
  logic [15:0] nxt_hi;
  // Constant sinks excluded: they may hold the pin for any time
  always_comb begin
    sink   = cond_i.uv | cond_i.bias | cond_i.tsd1 | cond_i.tsd2;
    kick   = frame_i.valid & frame_i.crc_ok & frame_i.addr_match & !frame_i.broadcast;
    nxt_hi = (fault_pin_oe_o && !sink) ? hi_ff + 16'h1 : 16'h0;
  end
  always_ff @(posedge clk_i) begin
    hi_ff <= reset_i ? 16'h0 : nxt_hi;
  end
  // --------
  // Properties
  // --------
  a_uv_sink: assert property (cond_i.uv |=> fault_pin_oe_o && !outputs_enable_o)
    else $error("undervoltage did not sink pin");
  a_bias_sink: assert property (cond_i.bias |=> fault_pin_oe_o)
    else $error("bias fault did not sink pin");
  a_ot_off: assert property (cond_i.tsd1 |=> fault_pin_oe_o && !outputs_enable_o)
    else $error("overtemperature did not stop outputs");
  a_ot2_sink: assert property (cond_i.tsd2 |=> fault_pin_oe_o)
    else $error("shutdown did not sink pin");
  a_pulse_start: assert property ($rose(cond_i.low_supply) && !sink && !cond_i.undervoltage_lockout
    |-> ##[1:3] fault_pin_oe_o)
    else $error("low supply gave no pulse");
  a_pulse_len: assert property (hi_ff <= PULSE_CYC + 1)
    else $error("fault pulse too long");
  a_lockout_por: assert property (cond_i.undervoltage_lockout |=> !outputs_enable_o && !failsafe_o)
    else $error("lockout left outputs on");
  a_fs_select: assert property ($rose(failsafe_o)
    |-> failsafe_state_o == $past(failsafe_select_pin_i))
    else $error("wrong fail-safe state");
  a_kick_hold: assert property (kick && !failsafe_o && watchdog_period_nonvolatile_i != 4'hf
    |=> !failsafe_o [*8])
    else $error("fail-safe right after kick");
  a_nv_direct: assert property ((watchdog_period_nonvolatile_i == 4'hf && !cond_i.undervoltage_lockout
    && !cond_i.tsd2) [*4] |-> ##[0:2] failsafe_o)
    else $error("forced fail-safe not entered");
endmodule : fmw_checker

bind fmw_top fmw_checker #(.PULSE_CYC(PULSE_CYC)) chk_u (
  .clk_i(clk_i), .reset_i(reset_i), .cond_i(cond_i), .frame_i(frame_i),
  .failsafe_select_pin_i(failsafe_select_pin_i),
  .watchdog_period_nonvolatile_i(watchdog_period_nonvolatile_i),
  .fault_pin_oe_o(fault_pin_oe_o), .outputs_enable_o(outputs_enable_o),
  .failsafe_o(failsafe_o), .failsafe_state_o(failsafe_state_o)
);

//--- tb/fmw_host_model.sv
`timescale 1ns/1ps
module fmw_host_model (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          reset_i,
  // Traffic control
  input  wire logic          bad_i,
  input  wire logic [7:0]    gap_i,
  // Frame status
  output fmw_pkg::fmw_frame_t frame_o
);
  import fmw_pkg::*;
  logic [7:0] cnt_ff;
  logic [1:0] kind_ff;
  // frame kinds: bad ones rotate checksum, address and broadcast faults
  always @(posedge clk_i) begin
    if (reset_i) begin
      cnt_ff  <= 8'h0;
      kind_ff <= 2'h0;
      frame_o <= 4'h0;
    end else if (cnt_ff >= gap_i) begin
      cnt_ff  <= 8'h0;
      kind_ff <= kind_ff + 2'h1;
      frame_o <= !bad_i ? 4'he : (kind_ff == 2'h0) ? 4'ha : (kind_ff == 2'h1) ? 4'hc : 4'hf;
    end else begin
      cnt_ff  <= cnt_ff + 8'h1;
      frame_o <= 4'h0;
    end
  end
endmodule : fmw_host_model

//--- tb/tb_fault_monitor_and_watchdog.sv
`timescale 1ns/1ps
module tb_fault_monitor_and_watchdog;
  import fmw_pkg::*;
  localparam int PC = 20;
  localparam logic [31:0] DEF = {12'h0, LST_RST, DPW_RST, WD_PERIOD_RST, 4'h0};
  logic        clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd, mdl;
  logic [31:0] lfsr = 32'h6ee0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic        hready, hresp, pin, oe, oen, supp, fs, fss;
  fmw_cond_t   cond = '0;
  fmw_frame_t  frame;
  logic [11:0] ch_on = 12'h0;
  logic [11:0] ch_low = 12'h0;
  logic        fs_pin = 1'b0;
  logic        bad = 1'b0;
  logic [3:0]  nv = 4'h0;
  logic [7:0]  lst, thr;
  logic [7:0]  gap = 8'h1e;
  logic [1:0]  dpw;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          hi, w, ch;
  int          cbit[5] = '{0, 3, 2, 1, 4};
  int          fbit[5] = '{2, 5, 3, 4, 6};

  always #4 clk_i = ~clk_i;

  fmw_top #(.PULSE_CYC(PC), .WD_CYC(10), .N(12)) dut_u (
    .clk_i(clk_i), .reset_i(reset_i), .hsel_i(1'b1), .haddr_i(haddr),
    .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
    .cond_i(cond), .ch_on_i(ch_on), .ch_headroom_low_i(ch_low), .frame_i(frame),
    .failsafe_select_pin_i(fs_pin), .watchdog_period_nonvolatile_i(nv),
    .fault_pin_o(pin), .fault_pin_oe_o(oe), .outputs_enable_o(oen),
    .suppress_diag_o(supp), .low_supply_threshold_o(lst), .failsafe_o(fs),
    .failsafe_state_o(fss)
  );
  fmw_host_model host_u (
    .clk_i(clk_i), .reset_i(reset_i), .bad_i(bad), .gap_i(gap), .frame_o(frame)
  );

  // --------
  // Helpers
  // --------
  function automatic logic [31:0] nxt_rand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt_rand
  function automatic logic [31:0] cw(input logic [3:0] wd, input logic [3:0] dp,
                                     input logic [1:0] c);
    return {12'h0, thr, dp, wd, 2'h0, c};
  endfunction : cw
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask : cyc
  task automatic wait_fs(input logic v);
    for (int i = 0; i < 200 && fs !== v; i++) @(posedge clk_i);
  endtask : wait_fs
  // Hready is waited for even though this slave never stalls
  task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
    @(posedge clk_i);
    haddr  <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clk_i); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_i); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic rdf(input logic [31:0] e);
    bus(8'h04, 1'b0, 32'h0);
    chk(rd, e);
  endtask : rdf
  task automatic complete_run();
    if (error_cnt == 0 && n_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  initial begin
    repeat (30000) @(posedge clk_i);
    error_cnt++;
    complete_run();
  end

  // --------
  // Scenarios
  // --------
  initial begin
    cyc(5);
    reset_i <= 1'b0;
    cyc(2);
    bus(8'h0, 1'b0, 32'h0);
    chk(rd, DEF);
    chk(hresp, 1'b0);
    rdf(32'h3);
    bus(8'h0c, 1'b1, 32'hffffffff);
    bus(8'h0c, 1'b0, 32'h0);
    chk(rd, 32'h0);
    lfsr = nxt_rand(lfsr);
    thr = lfsr[7:0];
    bus(8'h0, 1'b1, cw(4'h8, 4'h3, 2'h1));
    rdf(32'h0);
    chk(lst, thr);
    bus(8'h0, 1'b0, 32'h0);
    chk(rd, cw(4'h8, 4'h3, 2'h0));
    // Pulsed then constant-sink faults
    for (int k = 0; k < 5; k++) begin
      mdl = (32'h1 << fbit[k]) | 32'h2;
      cond <= fmw_cond_t'(7'h1 << cbit[k]);
      if (k < 2) begin
        for (hi = 0; hi < 9 && oe !== 1'b1; hi++) @(posedge clk_i);
        for (hi = 0; hi < 99 && oe === 1'b1; hi++) @(posedge clk_i);
        chk(hi, PC);
      end else begin
        cyc(PC + 9);
        chk(oe, 1'b1);
        chk(pin, 1'b0);
        chk(oen, k == 3);
      end
      if (k == 0) begin
        chk(supp, 1'b1);
        ch_on <= 12'h1;
        ch_low <= 12'h1;
        cyc(520);
        ch_on <= 12'h0;
        ch_low <= 12'h0;
      end
      bus(8'h0, 1'b1, cw(4'h8, 4'h3, 2'h2));
      rdf(mdl);
      cond <= '0;
      cyc(3);
      chk(oe, 1'b0);
      chk(oen, 1'b1);
      chk(supp, 1'b0);
      bus(8'h0, 1'b1, cw(4'h8, 4'h3, 2'h2));
      rdf(32'h0);
    end
    // Open detection with a random width and channel
    lfsr = nxt_rand(lfsr);
    dpw = lfsr[1:0];
    ch = lfsr[7:4] % 12;
    w = (dpw + 1) * 125;
    bus(8'h0, 1'b1, cw(4'h8, {2'h0, dpw}, 2'h0));
    ch_low[ch] <= 1'b1;
    ch_on[ch] <= 1'b1;
    cyc(w - 10);
    ch_on <= 12'h0;
    cyc(4);
    rdf(32'h0);
    ch_on[ch] <= 1'b1;
    cyc(w + 10);
    chk(oe, 1'b1);
    mdl = 32'h82 | (32'h1 << (FLG_OPEN_LSB + ch));
    rdf(mdl);
    bus(8'h0, 1'b1, cw(4'h8, {2'h0, dpw}, 2'h2));
    rdf(mdl);
    ch_low <= 12'h0;
    cyc(w + 10);
    ch_on <= 12'h0;
    bus(8'h0, 1'b1, cw(4'h8, {2'h0, dpw}, 2'h2));
    rdf(32'h0);
    // Watchdog: only faulty frames unless bad is low
    bad <= 1'b1;
    gap <= 8'h4;
    bus(8'h0, 1'b1, cw(4'h0, 4'h3, 2'h0));
    cyc(300);
    chk(fs, 1'b0);
    for (int p = 0; p < 2; p++) begin
      fs_pin <= p[0];
      bad <= 1'b1;
      bus(8'h0, 1'b1, cw(4'h2, 4'h3, 2'h0));
      wait_fs(1'b1);
      chk(fs, 1'b1);
      chk(fss, p[0]);
      bus(ADDR_STAT, 1'b0, 32'h0);
      chk(rd, 32'h3 | (p << STAT_FS_BIT));
      bad <= 1'b0;
      cyc(200);
      chk(fs, 1'b0);
    end
    bad <= 1'b1;
    nv <= 4'hf;
    wait_fs(1'b1);
    chk(fs, 1'b1);
    nv <= 4'h0;
    bad <= 1'b0;
    cyc(50);
    // Shutdown and lockout restore defaults
    for (int k = 5; k < 7; k++) begin
      bus(8'h0, 1'b1, cw(4'h1, 4'h0, 2'h0));
      cond <= fmw_cond_t'(7'h1 << k);
      cyc(5);
      if (k == 5) chk(oe, 1'b1);
      cond <= '0;
      cyc(4);
      chk(oe, 1'b0);
      bus(8'h0, 1'b0, 32'h0);
      chk(rd, DEF);
      rdf(32'h3);
      bus(8'h0, 1'b1, DEF | 32'h1);
      rdf(32'h0);
    end
    complete_run();
  end
endmodule : tb_fault_monitor_and_watchdog
